//--- src/voc_pkg.sv
package voc_pkg;
	// register byte offsets
	localparam logic [11:0] CTL_OFS    = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] MASK_OFS   = 12'h008;

	// control register fields
	localparam int RESET_BIT   = 0;
	localparam int ENABLE_BIT  = 1;
	localparam int LTL_BIT     = 2;
	localparam int MODE_LSB    = 3;
	localparam int ACK1_BIT    = 8;
	localparam int ACK2_BIT    = 9;
	localparam int HBLANK_ERROR_ACK_BIT = 10;
	localparam int URN_ACK_BIT = 11;
	localparam int THR_ACK_BIT = 12;
	localparam int IEN_LSB     = 16;
	localparam int FLG_LSB     = 24;
	localparam int NFLAG       = 5;

	// flag positions inside the five-bit flag vector
	localparam int F_BUF1 = 0;
	localparam int F_BUF2 = 1;
	localparam int F_HBE  = 2;
	localparam int F_UNDERRUN_FLAG = 3;
	localparam int F_THR  = 4;

	// operating modes
	typedef enum logic [1:0] {
		VOC_MODE_REFRESH = 2'h0,
		VOC_MODE_STREAM  = 2'h1,
		VOC_MODE_MESSAGE = 2'h2
	} voc_mode_t;

	localparam logic [31:0] CTL_RESET_VAL = 32'h0000_0001;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
	localparam logic [1:0]  OB_FIRST      = 2'h1;
	localparam logic [1:0]  OB_SECOND     = 2'h2;
endpackage

//--- src/voc_sync2.sv
`timescale 1ns/1ns
// two-stage synchroniser for a bundle of pin levels
module voc_sync2 #(
	parameter int W = 4
) (
	input  wire logic         sys_clk, // clock
	input  wire logic         rst,     // sync reset
	input  wire logic         ce,      // clock enable
	input  wire logic [W-1:0] d,       // async levels
	output logic      [W-1:0] q        // synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} voc_sync_t;
	voc_sync_t st_r;
	voc_sync_t st_nxt;

	// first stage read only by the second stage
	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.s1 = d;
			st_nxt.s2 = st_r.s1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule

//--- src/voc_edge.sv
`timescale 1ns/1ns
// rising-edge pulse detector for synchronised levels
module voc_edge #(
	parameter int W = 4
) (
	input  wire logic         sys_clk, // clock
	input  wire logic         rst,     // sync reset
	input  wire logic         ce,      // clock enable
	input  wire logic [W-1:0] lvl,     // synchronised level
	output logic      [W-1:0] rise     // one-cycle pulse
);
	typedef struct packed {
		logic [W-1:0] prev;
	} voc_edge_t;
	voc_edge_t st_r;
	voc_edge_t st_nxt;

	// remember last level so a held level fires once
	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.prev = lvl;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rise = lvl & ~st_r.prev & {W{ce}};
endmodule

//--- src/voc_ctl.sv
`timescale 1ns/1ns
// Function
// (RULE_01) A one written to threshold_ack clears the threshold flag and its interrupt.
// (RULE_02) A threshold not acknowledged by next field's active start sets underrun.
// (RULE_03) After a missed acknowledge transfer goes on with the old pointers.
// (RULE_04) Each flag interrupts only while set and its enable bit is one.
// (RULE_05) In message mode software keeps buffer-2, underrun, threshold enables zero.
// (RULE_06) little_endian_select swaps only overlay packed data in refresh modes.
// (RULE_07) Software never sets output_enable in the write that sets reset.
// (RULE_08) Software starts the engine by reset, then release, then enable writes.
// (RULE_09) In refresh modes enabling output starts at the first image pixel.
// (RULE_10) In stream and message modes enabling output starts at buffer one.
// (RULE_11) In refresh and stream modes only software clears output_enable.
// (RULE_12) In message mode hardware clears output_enable when buffer one empties.
// (RULE_13) Disabled refresh output stops reads but framing and buffer flags run.
// (RULE_14) Disabled refresh output sends undefined data; reset halts it fully.
// (RULE_15) Enabling output acks both buffers in stream, buffer one in message mode.
// (RULE_16) A one written to hblank or underrun ack clears that flag and interrupt.
// (RULE_17) Flags stay set until acknowledged or reset; ack bits read as zero.
module voc_ctl (
	input  wire logic        sys_clk,       // 125 MHz clock
	input  wire logic        rst,           // sync reset, high
	input  wire logic        ce,            // clock enable
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction
	input  wire logic [11:0] paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	input  wire logic        ev_thr,        // threshold line reached
	input  wire logic        ev_active,     // active area of field starts
	input  wire logic        ev_buf1_done,  // buffer one drained
	input  wire logic        ev_buf2_done,  // buffer two drained
	input  wire logic        ev_hbe,        // hblank error seen
	input  wire logic        fetch_ready,   // memory fetch accepted
	input  wire logic [31:0] ovl_raw,       // overlay word from memory
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error
	output logic             irq,           // level interrupt
	output logic             engine_reset,  // engine held in reset
	output logic             fetch_en,      // memory reads allowed
	output logic             start_pulse,   // restart from first pixel/byte
	output logic      [1:0]  buf_eligible,  // buffers cleared to send
	output logic             load_new_ptr,  // new pointers taken at field
	output logic      [31:0] ovl_word       // overlay word, host order
);
	typedef struct packed {
		logic        reset;
		logic        enable;
		logic        ltl;
		voc_pkg::voc_mode_t mode;
		logic [4:0]  ien;
		logic [4:0]  flg;
		logic [4:0]  msk;
		logic        ptr_ok;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic        fetch_en;
		logic        start;
		logic [1:0]  elig;
		logic        load_ptr;
		logic [31:0] ovl;
	} voc_st_t;
	voc_st_t st_r;
	voc_st_t st_nxt;

	// pin-level events pass two flops, then an edge detector
	logic [4:0] ev_sync;
	logic [4:0] ev_rise;
	logic       fetch_ok;

	voc_sync2 #(.W(6)) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.d       ({fetch_ready, ev_hbe, ev_buf2_done, ev_buf1_done,
		           ev_active, ev_thr}),
		.q       ({fetch_ok, ev_sync})
	);

	voc_edge #(.W(5)) u_edge (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.lvl     (ev_sync),
		.rise    (ev_rise)
	);

	////////////////////////////////////////////////////////////////////////
	logic        wr_acc;
	logic        rd_acc;
	logic        hit;
	logic [31:0] ctl_view;
	logic        refresh;

	assign wr_acc = psel & penable & pwrite & ~st_r.pready;
	assign rd_acc = psel & penable & ~pwrite & ~st_r.pready;
	assign hit = (paddr == voc_pkg::CTL_OFS) | (paddr == voc_pkg::STATUS_OFS)
		| (paddr == voc_pkg::MASK_OFS);
	assign refresh = (st_r.mode == voc_pkg::VOC_MODE_REFRESH);

	// ack bits read as zero, flags shown in upper byte
	always_comb begin
		ctl_view = voc_pkg::ZERO_WORD;
		ctl_view[voc_pkg::RESET_BIT] = st_r.reset;
		ctl_view[voc_pkg::ENABLE_BIT] = st_r.enable;
		ctl_view[voc_pkg::LTL_BIT] = st_r.ltl;
		ctl_view[voc_pkg::MODE_LSB +: 2] = st_r.mode;
		ctl_view[voc_pkg::IEN_LSB +: voc_pkg::NFLAG] = st_r.ien;
		ctl_view[voc_pkg::FLG_LSB +: voc_pkg::NFLAG] = st_r.flg; // RULE_17
	end

	////////////////////////////////////////////////////////////////////////
	logic [4:0] set_v;
	logic [4:0] clr_v;
	logic       en_rise;
	logic       thr_miss;

	// a missed ack at active start raises underrun, pointers kept
	assign thr_miss = ev_rise[1] & st_r.flg[voc_pkg::F_THR]; // RULE_02

	always_comb begin
		st_nxt = st_r;
		set_v = '0;
		clr_v = '0;
		en_rise = 1'b0;
		if (ce) begin
			st_nxt.pready = wr_acc | rd_acc;
			st_nxt.pslverr = (wr_acc | rd_acc) & ~hit;
			st_nxt.start = 1'b0;
			st_nxt.load_ptr = 1'b0;
			if (rd_acc) begin
				case (paddr)
				voc_pkg::CTL_OFS:    st_nxt.prdata = ctl_view;
				voc_pkg::STATUS_OFS: st_nxt.prdata = {27'h000_0000, st_r.flg};
				voc_pkg::MASK_OFS:   st_nxt.prdata = {27'h000_0000, st_r.msk};
				default:             st_nxt.prdata = voc_pkg::ZERO_WORD;
				endcase
			end
			// event sources
			set_v[voc_pkg::F_BUF1] = ev_rise[2];
			set_v[voc_pkg::F_BUF2] = ev_rise[3];
			set_v[voc_pkg::F_HBE] = ev_rise[4];
			set_v[voc_pkg::F_UNDERRUN_FLAG] = thr_miss; // RULE_02
			set_v[voc_pkg::F_THR] = ev_rise[0];
			if (wr_acc && paddr == voc_pkg::CTL_OFS) begin
				st_nxt.reset = pwdata[voc_pkg::RESET_BIT];
				st_nxt.ltl = pwdata[voc_pkg::LTL_BIT];
				st_nxt.mode = voc_pkg::voc_mode_t'(pwdata[voc_pkg::MODE_LSB +: 2]);
				st_nxt.ien = pwdata[voc_pkg::IEN_LSB +: voc_pkg::NFLAG];
				st_nxt.enable = pwdata[voc_pkg::ENABLE_BIT]; // RULE_11
				en_rise = pwdata[voc_pkg::ENABLE_BIT] & ~st_r.enable;
				clr_v[voc_pkg::F_BUF1] = pwdata[voc_pkg::ACK1_BIT];
				clr_v[voc_pkg::F_BUF2] = pwdata[voc_pkg::ACK2_BIT];
				clr_v[voc_pkg::F_HBE] = pwdata[voc_pkg::HBLANK_ERROR_ACK_BIT]; // RULE_16
				clr_v[voc_pkg::F_UNDERRUN_FLAG] = pwdata[voc_pkg::URN_ACK_BIT]; // RULE_16
				clr_v[voc_pkg::F_THR] = pwdata[voc_pkg::THR_ACK_BIT]; // RULE_01
				// enable acks buffers per mode
				if (en_rise && st_nxt.mode == voc_pkg::VOC_MODE_STREAM) begin
					clr_v[voc_pkg::F_BUF1] = 1'b1; // RULE_15
					clr_v[voc_pkg::F_BUF2] = 1'b1; // RULE_15
				end else if (en_rise
					&& st_nxt.mode == voc_pkg::VOC_MODE_MESSAGE) begin
					clr_v[voc_pkg::F_BUF1] = 1'b1; // RULE_15
				end
				if (pwdata[voc_pkg::THR_ACK_BIT]) begin
					st_nxt.ptr_ok = 1'b1;
				end
			end
			if (wr_acc && paddr == voc_pkg::STATUS_OFS) begin
				clr_v = pwdata[voc_pkg::NFLAG-1:0];
			end
			if (wr_acc && paddr == voc_pkg::MASK_OFS) begin
				st_nxt.msk = pwdata[voc_pkg::NFLAG-1:0];
			end
			// set wins over clear; engine reset wipes flags
			st_nxt.flg = (st_r.flg & ~clr_v) | set_v; // RULE_17
			if (st_nxt.reset) begin
				st_nxt.flg = '0;
				st_nxt.enable = 1'b0;
			end
			// message end: hw drops enable with buffer one empty
			if (set_v[voc_pkg::F_BUF1]
				&& st_nxt.mode == voc_pkg::VOC_MODE_MESSAGE) begin
				st_nxt.enable = 1'b0; // RULE_12
			end
			// restart on enable rise, first pixel or first byte
			st_nxt.start = en_rise & ~st_nxt.reset; // RULE_09 RULE_10
			if (st_nxt.start) begin
				st_nxt.elig = (st_nxt.mode == voc_pkg::VOC_MODE_STREAM)
					? (voc_pkg::OB_FIRST | voc_pkg::OB_SECOND)
					: voc_pkg::OB_FIRST;
			end else begin
				st_nxt.elig = st_r.elig & ~set_v[1:0];
			end
			if (clr_v[voc_pkg::F_BUF1]) st_nxt.elig[0] = ~set_v[0];
			if (clr_v[voc_pkg::F_BUF2]) st_nxt.elig[1] = ~set_v[1];
			// new pointers only if acked; else old ones kept
			if (ev_rise[1]) begin
				// a fresh threshold left unacked keeps the old pointers
				st_nxt.load_ptr = st_r.ptr_ok & ~thr_miss; // RULE_03
				st_nxt.ptr_ok = 1'b0;
			end
			// reads stop when disabled; not gated by the answer, else deadlock
			st_nxt.fetch_en = st_nxt.enable & ~st_nxt.reset; // RULE_13 RULE_14
			// byte swap only for refresh overlay; word held while unanswered
			if (fetch_ok) begin
				st_nxt.ovl = (st_r.ltl && refresh) ? {ovl_raw[7:0],
					ovl_raw[15:8], ovl_raw[23:16], ovl_raw[31:24]}
					: ovl_raw; // RULE_06
			end
			st_nxt.irq = |(st_nxt.flg & st_r.ien & ~st_nxt.msk); // RULE_04
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.reset <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign irq = st_r.irq;
	assign engine_reset = st_r.reset;
	assign fetch_en = st_r.fetch_en;
	assign start_pulse = st_r.start;
	assign buf_eligible = st_r.elig;
	assign load_new_ptr = st_r.load_ptr;
	assign ovl_word = st_r.ovl;

	////////////////////////////////////////////////////////////////////////
	chk_thr_ack_clear: assert property (@(posedge sys_clk) disable iff (rst)
		ce && wr_acc && paddr == voc_pkg::CTL_OFS
		&& pwdata[voc_pkg::THR_ACK_BIT] && !set_v[voc_pkg::F_THR]
		|=> !st_r.flg[voc_pkg::F_THR]) // RULE_01
		else $error("threshold flag not cleared by ack");
	chk_underrun_flag_on_miss: assert property (@(posedge sys_clk) disable iff (rst)
		ce && thr_miss && !st_nxt.reset |=> st_r.flg[voc_pkg::F_UNDERRUN_FLAG]) // RULE_02
		else $error("missed ack did not raise underrun");
	chk_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
		ce |=> irq == |(st_r.flg & $past(st_r.ien) & ~st_r.msk)) // RULE_04
		else $error("irq does not follow flags and enables");
	chk_msg_enable_drop: assert property (@(posedge sys_clk) disable iff (rst)
		ce && set_v[voc_pkg::F_BUF1]
		&& st_nxt.mode == voc_pkg::VOC_MODE_MESSAGE |=> !st_r.enable) // RULE_12
		else $error("message end did not drop enable");
	chk_enable_hold: assert property (@(posedge sys_clk) disable iff (rst)
		ce && st_r.enable && !wr_acc && !st_r.reset
		&& st_r.mode != voc_pkg::VOC_MODE_MESSAGE |=> st_r.enable) // RULE_11
		else $error("hardware cleared enable");
	chk_start_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		ce && en_rise && !st_nxt.reset |=> start_pulse ##1 !start_pulse) // RULE_09
		else $error("start pulse wrong");
	chk_fetch_stop: assert property (@(posedge sys_clk) disable iff (rst)
		!st_r.enable |-> !fetch_en) // RULE_13
		else $error("fetch while disabled");
	chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
		ce && st_r.flg[voc_pkg::F_HBE] && !clr_v[voc_pkg::F_HBE]
		&& !st_nxt.reset |=> st_r.flg[voc_pkg::F_HBE]) // RULE_17
		else $error("hblank flag dropped");
	chk_hblank_error_ack: assert property (@(posedge sys_clk) disable iff (rst)
		ce && clr_v[voc_pkg::F_HBE] && !set_v[voc_pkg::F_HBE]
		|=> !st_r.flg[voc_pkg::F_HBE]) // RULE_16
		else $error("hblank ack ignored");
	chk_stream_ack: assert property (@(posedge sys_clk) disable iff (rst)
		ce && st_nxt.start && st_nxt.mode == voc_pkg::VOC_MODE_STREAM
		&& set_v[1:0] == 2'h0 |=> buf_eligible == 2'h3) // RULE_15
		else $error("stream enable did not ack both buffers");
	chk_swap: assert property (@(posedge sys_clk) disable iff (rst)
		ce && fetch_ok && !(st_r.ltl && refresh)
		|=> ovl_word == $past(ovl_raw)) // RULE_06
		else $error("overlay swapped outside refresh");
endmodule

//--- verification/voc_partner.sv
`timescale 1ns/1ns
// far side: event source and memory fetch responder
module voc_partner (
	input  wire logic        sys_clk,     // clock
	input  wire logic        rst,         // sync reset
	input  wire logic [4:0]  go,          // event request, one cycle
	input  wire logic        fetch_en,    // reads allowed
	input  wire logic [31:0] src,         // overlay word to serve
	output logic      [4:0]  ev,          // buf1,buf2,hbe,active,thr
	output logic             fetch_ready, // fetch answered
	output logic      [31:0] ovl_raw      // overlay data
);
	logic [2:0] age;

	////////////////////////////////////////////////////////////////
	// events held four cycles so level or edge capture both see them
	always_ff @(posedge sys_clk) begin
		age <= (go != 5'h00) ? 3'h0 : age + 3'h1;
		fetch_ready <= fetch_en & ~rst;
		if (rst)
			ev <= 5'h00;
		else if (go != 5'h00)
			ev <= go;
		else if (age == 3'h3)
			ev <= 5'h00;
	end

	// released bus shows the inverse, never a stale word
	assign ovl_raw = fetch_ready ? src : ~src;
endmodule

//--- verification/voc_ctl_tb_top.sv
`timescale 1ns/1ns
// bench for the video output control block
module voc_ctl_tb_top;
	logic        sys_clk, rst, psel, penable, pwrite, fetch_ready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, ovl_raw, ovl_word, src, q, b;
	logic        pready, pslverr, irq, engine_reset, fetch_en, err;
	logic        start_pulse, load_new_ptr;
	logic [1:0]  buf_eligible;
	logic [4:0]  go, ev;
	int          err_count, n_compared, n_start, n_load, n, s;

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	voc_partner FAR (.sys_clk(sys_clk), .rst(rst), .go(go),
		.fetch_en(fetch_en), .src(src), .ev(ev),
		.fetch_ready(fetch_ready), .ovl_raw(ovl_raw));

	voc_ctl DUT (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .ev_thr(ev[4]), .ev_active(ev[3]),
		.ev_buf1_done(ev[0]), .ev_buf2_done(ev[1]), .ev_hbe(ev[2]),
		.fetch_ready(fetch_ready), .ovl_raw(ovl_raw), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq),
		.engine_reset(engine_reset), .fetch_en(fetch_en),
		.start_pulse(start_pulse), .buf_eligible(buf_eligible),
		.load_new_ptr(load_new_ptr), .ovl_word(ovl_word));

	////////////////////////////////////////////////////////////////
	// one-cycle outputs counted in the cycle they stand
	always @(posedge sys_clk) begin
		if (start_pulse === 1'b1)
			n_start++;
		if (load_new_ptr === 1'b1)
			n_load++;
	end

	task conclude;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; idle edge first so no signal is set twice
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 40) begin
			err_count++;
			conclude();
		end
	endtask

	// control word: mode, enable, reset, endian, irq enables
	function automatic logic [31:0] cw(input logic [1:0] m,
			input logic e, input logic r, input logic l,
			input logic [4:0] ie);
		cw = {11'h000, ie, 11'h000, m, l, e, r};
	endfunction

	// poll one flag, bounded, then compare
	task wf(input int f, input logic v);
		for (n = 0; n < 20; n++) begin
			apb(1'b0, voc_pkg::CTL_OFS, 32'h0000_0000);
			if (q[voc_pkg::FLG_LSB + f] === v)
				break;
		end
		chk(q[voc_pkg::FLG_LSB + f], v);
	endtask

	task start(input logic [1:0] m, input logic l, input logic [4:0] ie);
		s = n_start;
		apb(1'b1, voc_pkg::CTL_OFS, cw(m, 1'b0, 1'b1, l, ie));
		apb(1'b1, voc_pkg::CTL_OFS, cw(m, 1'b0, 1'b0, l, ie));
		apb(1'b1, voc_pkg::CTL_OFS, cw(m, 1'b1, 1'b0, l, ie));
		for (n = 0; n < 20 && n_start == s; n++)
			@(posedge sys_clk);
		chk(n_start - s, 1);
	endtask

	task pulse(input logic [4:0] e);
		@(posedge sys_clk);
		go <= e;
		@(posedge sys_clk);
		go <= 5'h00;
	endtask

	// hang guard
	initial begin
		repeat (30000) @(posedge sys_clk);
		err_count++;
		conclude();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, go} = '0;
		src = 32'h1122_3344;
		{err_count, n_compared, n_start, n_load} = '0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		apb(1'b0, voc_pkg::CTL_OFS, 32'h0000_0000);
		chk(q, voc_pkg::CTL_RESET_VAL);
		chk(engine_reset, 1'b1);
		apb(1'b1, voc_pkg::MASK_OFS, 32'h0000_001F);
		apb(1'b0, voc_pkg::MASK_OFS, 32'h0000_0000);
		chk(q, 32'h0000_001F);
		apb(1'b1, voc_pkg::MASK_OFS, 32'h0000_0000);
		apb(1'b0, 12'hFFC, 32'h0000_0000);
		chk(err, 1'b1);
		$display("test reset done");
		start(voc_pkg::VOC_MODE_STREAM, 1'b1, 5'h00);
		chk(buf_eligible, 2'h3);
		repeat (6) @(posedge sys_clk);
		chk(ovl_word, src);
		pulse(5'h01);
		wf(voc_pkg::F_BUF1, 1'b1);
		chk(q[voc_pkg::ENABLE_BIT], 1'b1);
		$display("test stream done");
		// buffer one and hblank error irqs only: others stay off here
		start(voc_pkg::VOC_MODE_MESSAGE, 1'b0, 5'h05);
		chk(buf_eligible, 2'h1);
		pulse(5'h01);
		wf(voc_pkg::F_BUF1, 1'b1);
		chk(q[voc_pkg::ENABLE_BIT], 1'b0);
		chk(irq, 1'b1);
		b = cw(voc_pkg::VOC_MODE_MESSAGE, 1'b0, 1'b0, 1'b0, 5'h05);
		apb(1'b1, voc_pkg::CTL_OFS, b | 32'h0000_0100);
		wf(voc_pkg::F_BUF1, 1'b0);
		chk(irq, 1'b0);
		$display("test message done");
		start(voc_pkg::VOC_MODE_REFRESH, 1'b1, 5'h10);
		b = cw(voc_pkg::VOC_MODE_REFRESH, 1'b1, 1'b0, 1'b1, 5'h10);
		repeat (6) @(posedge sys_clk);
		apb(1'b0, voc_pkg::CTL_OFS, 32'h0000_0000);
		chk(q & 32'h001F_1FFF, b);
		chk(fetch_en, 1'b1);
		chk(ovl_word, {src[7:0], src[15:8], src[23:16], src[31:24]});
		pulse(5'h10);
		wf(voc_pkg::F_THR, 1'b1);
		chk(irq, 1'b1);
		apb(1'b1, voc_pkg::MASK_OFS, 32'h0000_0010);
		chk(irq, 1'b0);
		apb(1'b1, voc_pkg::MASK_OFS, 32'h0000_0000);
		chk(irq, 1'b1);
		apb(1'b1, voc_pkg::CTL_OFS, b | 32'h0000_1000);
		wf(voc_pkg::F_THR, 1'b0);
		chk(irq, 1'b0);
		pulse(5'h10);
		wf(voc_pkg::F_THR, 1'b1);
		s = n_load;
		pulse(5'h08);
		wf(voc_pkg::F_UNDERRUN_FLAG, 1'b1);
		chk(n_load - s, 0);
		chk(fetch_en, 1'b1);
		apb(1'b1, voc_pkg::CTL_OFS, b | 32'h0000_1800);
		wf(voc_pkg::F_UNDERRUN_FLAG, 1'b0);
		pulse(5'h04);
		wf(voc_pkg::F_HBE, 1'b1);
		chk(irq, 1'b0);
		apb(1'b1, voc_pkg::CTL_OFS, b | 32'h0000_0400);
		wf(voc_pkg::F_HBE, 1'b0);
		// acked threshold, so the next active start takes new pointers
		s = n_load;
		pulse(5'h08);
		repeat (8) @(posedge sys_clk);
		chk(n_load - s, 1);
		$display("test refresh flags done");
		apb(1'b1, voc_pkg::CTL_OFS, b & 32'hFFFF_FFFD);
		for (n = 0; n < 20 && fetch_en !== 1'b0; n++)
			@(posedge sys_clk);
		chk(fetch_en, 1'b0);
		pulse(5'h01);
		wf(voc_pkg::F_BUF1, 1'b1);
		apb(1'b1, voc_pkg::STATUS_OFS, 32'h0000_001F);
		apb(1'b0, voc_pkg::STATUS_OFS, 32'h0000_0000);
		chk(q, voc_pkg::ZERO_WORD);
		apb(1'b1, voc_pkg::CTL_OFS, (b & 32'hFFFF_FFFD) | 32'h0000_0001);
		chk(fetch_en, 1'b0);
		chk(engine_reset, 1'b1);
		$display("test disable done");
		conclude();
	end
endmodule
